// [modem_status_consts.svh]
// register offsets, field positions and reset values of the modem status block
`ifndef MODEM_STATUS_CONSTS_SVH
`define MODEM_STATUS_CONSTS_SVH

// register byte offsets, one aligned word each
`define OFF_MODEM_STATUS 8'h00
`define OFF_SCRATCH 8'h04
`define OFF_MODEM_CONTROL 8'h08
`define OFF_ENH_FEATURE 8'h0C
`define OFF_INT_STATUS 8'h10
`define OFF_INT_CLEAR 8'h14
`define OFF_INT_ENABLE 8'h18

// modem status field positions
`define MS_CTS_DELTA 0
`define MS_DSR_DELTA 1
`define MS_RI_TRAIL 2
`define MS_CD_DELTA 3
`define MS_CTS_LVL 4
`define MS_DSR_LVL 5
`define MS_RI_LVL 6
`define MS_CD_LVL 7

// enhanced feature control field position
`define EF_AUTO_CTS 7

// reset values
`define SCRATCH_RST 8'h00
`define CTRL_RST 5'h00
`define AUTO_CTS_RST 1'h0
`define INT_RST 4'h0
`define PINS_IDLE 4'hF
`define READ_IDLE 8'h00

`endif

// [modem_status_pkg.sv]
// types shared by the modem status block
package modem_status_pkg;

	// one register access from the host
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// handshake pins, all active low, bit order cts, dsr, ri, cd from bit 0
	typedef struct packed {
		logic cd_b;
		logic ri_b;
		logic dsr_b;
		logic cts_b;
	} modem_pins_t;

	// modem control register layout, bits 4 down to 0
	typedef struct packed {
		logic loop;
		logic userOutputTwo;
		logic userOutputOne;
		logic rts;
		logic dtr;
	} modem_ctrl_t;

	// whole state of the top module
	typedef struct packed {
		logic [7:0] scratch;
		modem_ctrl_t ctrl;
		logic autoCts;
		logic [3:0] intStatus;
		logic [3:0] intEnable;
		logic [7:0] rdData;
		logic modemIrq;
		logic irq;
		logic txHold;
	} top_state_t;

endpackage : modem_status_pkg

// [modem_pin_sync.sv]
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps

module modem_pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// pins and their synchronised copy
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// first stage feeds only the second stage
	always_comb begin
		st_d = st_q;
		st_d.stage1 = pinIn;
		st_d.stage2 = st_q.stage1;
	end

	// reset to the idle pin level
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= {IDLE, IDLE};
		end else begin
			st_q <= st_d;
		end
	end

	assign pinSync = st_q.stage2;

endmodule : modem_pin_sync

// [modem_delta_cell.sv]
// sticky change flag for one modem status level
`timescale 1ns/1ps

module modem_delta_cell #(
	parameter bit FALL_ONLY = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// watched level and read clear
	input wire logic level,
	input wire logic clr,
	// sticky flag and one-cycle set pulse
	output logic flag,
	output logic hit
);

	typedef struct packed {
		logic primed;
		logic prev;
		logic flag;
		logic hit;
	} cell_state_t;

	cell_state_t st_q;
	cell_state_t st_d;
	logic event_now;

	// first cycle after reset only learns the level, but the synchroniser resets to idle, so a pin held active through reset is flagged unless FALL_ONLY
	always_comb begin
		st_d = st_q;
		event_now = st_q.primed & (FALL_ONLY ? (st_q.prev & ~level) : (st_q.prev ^ level));
		st_d.primed = 1'b1;
		st_d.prev = level;
		st_d.hit = event_now;
		st_d.flag = event_now | (st_q.flag & ~clr); // set beats clear
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flag = st_q.flag;
	assign hit = st_q.hit;

endmodule : modem_delta_cell

// [uart_modem_status_scratch.sv]
// modem status, change flags, auto clear-to-send hold and scratch register of one channel
//
// Behaviour
// - auto clear-to-send holds transmitter after current character
// - bit 4 is inverted cts, loop-back rts
// - bit 3 flags carrier-detect change since read
// - bit 2 flags ring pin low to high
// - bit 1 flags data-set-ready change since read
// - bit 0 flags clear-to-send change since read
// - modem interrupt while any change flag set
// - eight bit scratch register, plain read back
// - reading modem status clears change flags
// - bits 7..5 inverted pins, loop-back control bits
`include "modem_status_consts.svh"
`timescale 1ns/1ps

module uart_modem_status_scratch (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register port
	input modem_status_pkg::reg_req_t regReq,
	output logic [7:0] rdData,
	// modem handshake pins
	input modem_status_pkg::modem_pins_t modemPins,
	// transmitter handshake
	input wire logic txBusy,
	input wire logic txCharDone,
	output logic txHold,
	// interrupts
	output logic modemIrq,
	output logic irq
);

	modem_status_pkg::top_state_t st_q;
	modem_status_pkg::top_state_t st_d;
	modem_status_pkg::modem_pins_t pinSync;
	logic [3:0] level;
	logic [3:0] flags;
	logic [3:0] hits;
	logic statusRead;
	logic holdReq;

	// pins are asynchronous to core_clk
	modem_pin_sync #(
		.WIDTH(4),
		.IDLE(`PINS_IDLE)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pinIn(modemPins),
		.pinSync(pinSync)
	);

	// status levels: inverted pins, or control bits when looped back
	always_comb begin
		if (st_q.ctrl.loop) begin
			level = {st_q.ctrl.userOutputTwo, st_q.ctrl.userOutputOne, st_q.ctrl.dtr, st_q.ctrl.rts};
		end else begin
			level = ~{pinSync.cd_b, pinSync.ri_b, pinSync.dsr_b, pinSync.cts_b};
		end
	end

	assign statusRead = regReq.rd && (regReq.addr == `OFF_MODEM_STATUS);

	// one change cell per level; ring flags only its trailing edge
	generate
		for (genvar i = 0; i < 4; i++) begin : g_delta
			modem_delta_cell #(
				.FALL_ONLY(i == `MS_RI_TRAIL)
			) u_cell (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.level(level[i]),
				.clr(statusRead),
				.flag(flags[i]),
				.hit(hits[i])
			);
		end
	endgenerate

	// hold only applies while cts reads inactive, i.e. the pin is high
	assign holdReq = st_q.autoCts & ~level[0];

	// register writes, read mux, interrupts and transmitter hold
	always_comb begin
		st_d = st_q;
		if (regReq.wr) begin
			unique case (regReq.addr)
				`OFF_SCRATCH: st_d.scratch = regReq.wdata;
				`OFF_MODEM_CONTROL: st_d.ctrl = regReq.wdata[4:0];
				`OFF_ENH_FEATURE: st_d.autoCts = regReq.wdata[`EF_AUTO_CTS];
				`OFF_INT_ENABLE: st_d.intEnable = regReq.wdata[3:0];
				default: st_d.scratch = st_q.scratch;
			endcase
		end
		// write-one-to-clear, a new event in the same cycle stays set
		if (regReq.wr && (regReq.addr == `OFF_INT_CLEAR)) begin
			st_d.intStatus = (st_q.intStatus & ~regReq.wdata[3:0]) | hits;
		end else begin
			st_d.intStatus = st_q.intStatus | hits;
		end
		// read data stands for one cycle only, unmapped reads give zero
		st_d.rdData = `READ_IDLE;
		if (regReq.rd) begin
			unique case (regReq.addr)
				`OFF_MODEM_STATUS: st_d.rdData = {level, flags};
				`OFF_SCRATCH: st_d.rdData = st_q.scratch;
				`OFF_MODEM_CONTROL: st_d.rdData = {3'h0, st_q.ctrl};
				`OFF_ENH_FEATURE: st_d.rdData = {st_q.autoCts, 7'h00};
				`OFF_INT_STATUS: st_d.rdData = {4'h0, st_q.intStatus};
				`OFF_INT_ENABLE: st_d.rdData = {4'h0, st_q.intEnable};
				default: st_d.rdData = `READ_IDLE;
			endcase
		end
		st_d.modemIrq = |flags;
		st_d.irq = |(st_d.intStatus & st_d.intEnable);
		// a character already on the wire finishes before the hold takes effect
		st_d.txHold = holdReq & (st_q.txHold | ~txBusy | txCharDone);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q.scratch <= `SCRATCH_RST;
			st_q.ctrl <= `CTRL_RST;
			st_q.autoCts <= `AUTO_CTS_RST;
			st_q.intStatus <= `INT_RST;
			st_q.intEnable <= `INT_RST;
			st_q.rdData <= `READ_IDLE;
			st_q.modemIrq <= 1'b0;
			st_q.irq <= 1'b0;
			st_q.txHold <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign rdData = st_q.rdData;
	assign modemIrq = st_q.modemIrq;
	assign irq = st_q.irq;
	assign txHold = st_q.txHold;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence SEQ_SCR_WR;
		regReq.wr && (regReq.addr == `OFF_SCRATCH);
	endsequence

	sequence SEQ_SCR_RD;
		regReq.rd && (regReq.addr == `OFF_SCRATCH);
	endsequence

	sequence SEQ_MID_CHAR;
		txBusy && !txCharDone && !txHold;
	endsequence

	AST_AUTO_CTS_OFF: assert property (!st_q.autoCts |=> !txHold)
		else $error("transmitter held with auto cts disabled");

	AST_HOLD_WAITS: assert property (SEQ_MID_CHAR |=> !txHold)
		else $error("transmitter held in the middle of a character");

	AST_HOLD_IDLE: assert property (holdReq && !txBusy |=> txHold)
		else $error("idle transmitter not held while cts high");

	AST_CTS_LEVEL: assert property (statusRead && !st_q.ctrl.loop |=> rdData[`MS_CTS_LVL] == ~$past(pinSync.cts_b))
		else $error("status bit 4 is not the inverse of cts");

	AST_LOOP_LEVELS: assert property (statusRead && st_q.ctrl.loop |=>
		rdData[7:4] == $past({st_q.ctrl.userOutputTwo, st_q.ctrl.userOutputOne, st_q.ctrl.dtr, st_q.ctrl.rts}))
		else $error("loop-back levels do not follow modem control");

	AST_CD_CHANGE: assert property (g_delta[3].u_cell.st_q.primed && $changed(level[`MS_CD_DELTA]) |=> flags[`MS_CD_DELTA])
		else $error("carrier detect change not flagged");

	AST_RI_TRAIL: assert property ($rose(flags[`MS_RI_TRAIL]) |-> $past(level[`MS_RI_TRAIL], 2) && !$past(level[`MS_RI_TRAIL]))
		else $error("ring flag set without pin going low to high");

	AST_DSR_CHANGE: assert property (g_delta[1].u_cell.st_q.primed && $changed(level[`MS_DSR_DELTA]) |=> flags[`MS_DSR_DELTA])
		else $error("data set ready change not flagged");

	AST_CTS_CHANGE: assert property (g_delta[0].u_cell.st_q.primed && $changed(level[`MS_CTS_DELTA]) |=> flags[`MS_CTS_DELTA])
		else $error("clear to send change not flagged");

	AST_MODEM_IRQ: assert property ((|flags) |=> modemIrq)
		else $error("modem interrupt missing while a flag is set");

	AST_MODEM_IRQ_LOW: assert property (!(|flags) |=> !modemIrq)
		else $error("modem interrupt raised with no flag set");

	AST_SCRATCH_BACK: assert property (SEQ_SCR_WR ##1 SEQ_SCR_RD |=> rdData == $past(regReq.wdata, 2))
		else $error("scratch read back differs from write");

	AST_READ_CLEARS: assert property (statusRead ##1 (hits == 4'h0) |-> flags == 4'h0)
		else $error("status read did not clear change flags");

	AST_SET_WINS: assert property (statusRead && g_delta[0].u_cell.event_now |=> flags[`MS_CTS_DELTA])
		else $error("change during status read was lost");

endmodule : uart_modem_status_scratch

// [modem_partner.sv]
// behavioural modem that drives the four active-low handshake pins
`timescale 1ns/1ps

module modem_partner (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// level the scenario asks for, and the pins as driven
	input modem_status_pkg::modem_pins_t pinWant,
	output modem_status_pkg::modem_pins_t modemPins
);
	// pins move just after an edge, so they reach the synchroniser at an unrelated moment
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			modemPins <= #2 4'hF;
		end else begin
			modemPins <= #2 pinWant;
		end
	end
endmodule : modem_partner

// [uart_modem_status_scratch_bench.sv]
// self-checking bench for the modem status and scratch block
`timescale 1ns/1ps
`include "modem_status_consts.svh"

module uart_modem_status_scratch_bench;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	modem_status_pkg::reg_req_t regReq = '0;
	modem_status_pkg::modem_pins_t pinWant = 4'hF;
	modem_status_pkg::modem_pins_t modemPins;
	modem_status_pkg::modem_pins_t p;
	logic txBusy = 1'b0;
	logic txCharDone = 1'b0;
	logic [7:0] rdData;
	logic txHold;
	logic modemIrq;
	logic irq;
	logic [3:0] flagExp = 4'h0;
	logic [3:0] intExp = 4'h0;
	logic [7:0] v;
	logic [7:0] got;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	uart_modem_status_scratch DUT (.core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .rdData(rdData),
		.modemPins(modemPins), .txBusy(txBusy), .txCharDone(txCharDone), .txHold(txHold),
		.modemIrq(modemIrq), .irq(irq));
	modem_partner modem (.core_clk(core_clk), .rst_b(rst_b), .pinWant(pinWant), .modemPins(modemPins));

	// free-running clock, 10 ns period
	always #5 core_clk = ~core_clk;

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		regReq.wr <= 1'b0;
	endtask : wr_reg

	// data stand only in the cycle after the strobe edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		regReq.rd <= 1'b0;
		#1 d = rdData;
	endtask : rd_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
		logic [7:0] d;
		rd_reg(a, d);
		check(d, e, what);
	endtask : rd_chk

	// levels are the pins inverted, change flags below them
	function automatic logic [7:0] exp_ms(input modem_status_pkg::modem_pins_t q, input logic [3:0] f);
		return {~q.cd_b, ~q.ri_b, ~q.dsr_b, ~q.cts_b, f};
	endfunction : exp_ms

	// ring flags only on the pin going low to high, others on any change
	function automatic logic [3:0] step_flags(input modem_status_pkg::modem_pins_t o,
		input modem_status_pkg::modem_pins_t n);
		return {o.cd_b ^ n.cd_b, ~o.ri_b & n.ri_b, o.dsr_b ^ n.dsr_b, o.cts_b ^ n.cts_b};
	endfunction : step_flags

	task automatic wait_chk(input int n, input logic e, input string what);
		repeat (n) @(posedge core_clk);
		#1 check({7'h00, txHold}, {7'h00, e}, what);
	endtask : wait_chk

	// main sequence
	initial begin
		void'($urandom(97));
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		rd_chk(`OFF_MODEM_STATUS, 8'h00, "status reset");
		rd_chk(`OFF_SCRATCH, `SCRATCH_RST, "scratch reset");
		rd_chk(8'h1C, `READ_IDLE, "unmapped read");
		// scratch write and read back, back to back with the status register
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom());
			wr_reg(`OFF_SCRATCH, v);
			rd_chk(`OFF_MODEM_STATUS, 8'h00, "status untouched");
			rd_chk(`OFF_SCRATCH, v, "scratch");
		end
		// single pin toggles first, then random patterns; every other step reads and clears
		for (int i = 0; i < 24; i++) begin
			p = (i < 8) ? (pinWant ^ (4'h1 << (i % 4))) : 4'($urandom());
			flagExp = flagExp | step_flags(pinWant, p);
			intExp = intExp | step_flags(pinWant, p);
			@(posedge core_clk);
			pinWant <= p;
			repeat (7) @(posedge core_clk);
			#1 check({7'h00, modemIrq}, {7'h00, |flagExp}, "modem irq");
			if (i % 2 == 1) begin
				rd_chk(`OFF_MODEM_STATUS, exp_ms(p, flagExp), "status");
				flagExp = 4'h0;
				rd_chk(`OFF_MODEM_STATUS, exp_ms(p, 4'h0), "status cleared");
			end
		end
		rd_chk(`OFF_MODEM_STATUS, exp_ms(pinWant, flagExp), "status last");
		// interrupt status is sticky, masked by enable, cleared by writing ones
		rd_chk(`OFF_INT_STATUS, {4'h0, intExp}, "int status");
		wr_reg(`OFF_INT_ENABLE, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 check({7'h00, irq}, 8'h00, "irq masked");
		wr_reg(`OFF_INT_ENABLE, 8'h0F);
		repeat (2) @(posedge core_clk);
		#1 check({7'h00, irq}, {7'h00, |intExp}, "irq enabled");
		rd_chk(`OFF_INT_ENABLE, 8'h0F, "int enable");
		wr_reg(`OFF_INT_CLEAR, 8'h0F);
		repeat (2) @(posedge core_clk);
		#1 check({7'h00, irq}, 8'h00, "irq cleared");
		rd_chk(`OFF_INT_STATUS, 8'h00, "int status cleared");
		// loop-back: levels follow the control bits, not the pins
		for (int i = 0; i < 5; i++) begin
			v = (8'($urandom()) & 8'h0F) | 8'h10;
			wr_reg(`OFF_MODEM_CONTROL, v);
			rd_chk(`OFF_MODEM_CONTROL, v, "control");
			rd_reg(`OFF_MODEM_STATUS, got);
			rd_chk(`OFF_MODEM_STATUS, {v[3], v[2], v[0], v[1], 4'h0}, "loop status");
		end
		wr_reg(`OFF_MODEM_CONTROL, 8'h00);
		rd_reg(`OFF_MODEM_STATUS, got);
		// clear-to-send pin high holds nothing while auto flow control is off
		@(posedge core_clk);
		pinWant <= 4'hF;
		txBusy <= 1'b1;
		wait_chk(7, 1'b0, "hold while disabled");
		wr_reg(`OFF_ENH_FEATURE, 8'h80);
		rd_chk(`OFF_ENH_FEATURE, 8'h80, "feature control");
		wait_chk(4, 1'b0, "hold waits for character");
		@(posedge core_clk);
		txCharDone <= 1'b1;
		@(posedge core_clk);
		txCharDone <= 1'b0;
		txBusy <= 1'b0;
		#1 check({7'h00, txHold}, 8'h01, "hold after character");
		@(posedge core_clk);
		pinWant <= 4'hE;
		wait_chk(7, 1'b0, "hold released");
		report_and_stop();
	end
endmodule : uart_modem_status_scratch_bench
